/* File: hdl/mfr_read_front.sv */
// serial flash multi-bit read command front end
`timescale 1ns/100ps

module mfr_read_front
   import mfr_pkg::*;
#(
   parameter int ARRAY_ADDR_W = 24
) (
   input wire logic core_clk, // system clock
   input wire logic rst, // asynchronous reset, high
   input wire logic serial_clk, // link clock from host
   input wire logic chip_sel_n, // chip select, low active
   input wire logic [3:0] io_in, // io line levels
   output logic [3:0] io_out, // io line drive values
   output logic [3:0] io_oe, // io line drive enables
   input wire logic extended_address_flag, // narrow commands go wide
   input wire logic [7:0] configuration_register_one, // quad, latency
   input wire logic enhanced_latency, // mode cycles present on two-bit io reads
   output logic [ARRAY_ADDR_W-1:0] mem_addr, // array read address
   input wire logic [7:0] mem_rdata, // array byte, one cycle late
   output logic continuous_read // instruction-less mode
);

   initial begin
      if (ARRAY_ADDR_W < 8 || ARRAY_ADDR_W > 32) begin
         $error("ARRAY_ADDR_W must lie in 8..32");
      end
   end

   // ------------------------------------------------------------
   // synchronisers and edge detection
   // ------------------------------------------------------------
   logic sck_s1, sck_s2, sck_s3;
   logic cs_s1, cs_s2, cs_s3;
   logic [3:0] io_s1, io_s2;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_s3 <= 1'b0;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
         io_s1 <= 4'h0;
         io_s2 <= 4'h0;
      end else begin
         sck_s1 <= serial_clk;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         cs_s1 <= chip_sel_n;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         io_s1 <= io_in;
         io_s2 <= io_s1;
      end
   end

   logic sck_rise, sck_fall, cs_act, cs_fall, cs_rise;
   assign sck_rise = sck_s2 & ~sck_s3 & cs_act;
   assign sck_fall = ~sck_s2 & sck_s3 & cs_act;
   assign cs_act = ~cs_s2;
   assign cs_fall = ~cs_s2 & cs_s3;
   assign cs_rise = cs_s2 & ~cs_s3;

   // ------------------------------------------------------------
   // decoding helpers
   // ------------------------------------------------------------
   function automatic logic [5:0] addr_steps(input logic wide,
                                             input logic two_bit);
      logic [5:0] bits;
      bits = wide ? ADDR_BITS_WIDE : ADDR_BITS_NARROW;
      return two_bit ? {1'b0, bits[5:1]} : bits;
   endfunction

   function automatic logic [5:0] dummy_len(input mfr_kind_e k,
                                            input logic [1:0] code);
      logic [5:0] n;
      n = 6'h00;
      if (k == KIND_TWO_IO) begin
         unique case (code)
            2'h0: n = IO_DUMMY_CODE0;
            2'h1: n = IO_DUMMY_CODE1;
            2'h2: n = IO_DUMMY_CODE2;
            2'h3: n = IO_DUMMY_CODE3;
         endcase
      end else begin
         n = (code == LAT_CODE_NO_DUMMY) ? 6'h00 : OUT_DUMMY_CYCLES;
      end
      return n;
   endfunction

   mfr_state_e state;
   logic [5:0] cnt;
   logic [7:0] instr;
   mfr_kind_e kind;
   logic wide;
   logic cont_frame;
   logic [1:0] lat_code;
   logic quad_en;
   assign lat_code = configuration_register_one[LAT_CODE_MSB:LAT_CODE_LSB];
   assign quad_en = configuration_register_one[QUAD_ENABLE_BIT];

   logic [7:0] next_instr;
   logic dec_valid, dec_wide;
   mfr_kind_e dec_kind;

   always_comb begin
      next_instr = {instr[6:0], io_s2[0]};
      dec_valid = 1'b1;
      dec_kind = KIND_TWO_OUT;
      dec_wide = extended_address_flag;
      unique case (next_instr)
         CMD_TWO_OUT: dec_kind = KIND_TWO_OUT;
         CMD_TWO_OUT_WIDE: dec_wide = 1'b1;
         CMD_FOUR_OUT: begin
            dec_kind = KIND_FOUR_OUT;
            dec_valid = quad_en;
         end
         CMD_FOUR_OUT_WIDE: begin
            dec_kind = KIND_FOUR_OUT;
            dec_wide = 1'b1;
            dec_valid = quad_en;
         end
         CMD_TWO_IO: dec_kind = KIND_TWO_IO;
         CMD_TWO_IO_WIDE: begin
            dec_kind = KIND_TWO_IO;
            dec_wide = 1'b1;
         end
         default: dec_valid = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // command sequencer
   // ------------------------------------------------------------
   logic launch;
   assign launch = sck_fall &
      ((state == ST_DUMMY && cnt == 6'h00) || state == ST_DATA);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         cnt <= 6'h00;
         instr <= 8'h00;
         kind <= KIND_TWO_OUT;
         wide <= 1'b0;
      end else if (!cs_act) begin
         state <= ST_IDLE;
         cnt <= 6'h00;
      end else if (cs_fall) begin
         if (continuous_read) begin
            state <= ST_ADDR;
            cnt <= addr_steps(wide, 1'b1);
         end else begin
            state <= ST_CMD;
            cnt <= INSTR_BITS;
         end
      end else begin
         unique case (state)
            ST_IDLE: ;
            ST_CMD: if (sck_rise) begin
               instr <= next_instr;
               cnt <= cnt - 6'h01;
               if (cnt == 6'h01) begin
                  if (dec_valid) begin
                     state <= ST_ADDR;
                     kind <= dec_kind;
                     wide <= dec_wide;
                     cnt <= addr_steps(dec_wide, dec_kind == KIND_TWO_IO);
                  end else begin
                     state <= ST_IDLE; // ignored until deselect
                  end
               end
            end
            ST_ADDR: if (sck_rise) begin
               cnt <= cnt - 6'h01;
               if (cnt == 6'h01) begin
                  if (kind == KIND_TWO_IO && enhanced_latency) begin
                     state <= ST_MODE;
                     cnt <= MODE_CYCLES;
                  end else begin
                     state <= ST_DUMMY;
                     cnt <= dummy_len(kind, lat_code);
                  end
               end
            end
            ST_MODE: if (sck_rise) begin
               cnt <= cnt - 6'h01;
               if (cnt == 6'h01) begin
                  state <= ST_DUMMY;
                  cnt <= dummy_len(kind, lat_code);
               end
            end
            ST_DUMMY: if (sck_fall) begin
               if (cnt == 6'h00) begin
                  state <= ST_DATA;
               end else begin
                  cnt <= cnt - 6'h01;
               end
            end
            ST_DATA: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // address capture and auto increment
   // ------------------------------------------------------------
   logic [31:0] addr_sr, next_addr_sr;
   logic [1:0] gidx;

   always_comb begin
      next_addr_sr = (kind == KIND_TWO_IO) ?
         {addr_sr[29:0], io_s2[1:0]} : {addr_sr[30:0], io_s2[0]};
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         addr_sr <= 32'h0000_0000;
         mem_addr <= '0;
      end else if (cs_fall) begin
         addr_sr <= 32'h0000_0000;
      end else if (state == ST_ADDR && sck_rise) begin
         addr_sr <= next_addr_sr;
         if (cnt == 6'h01) begin
            mem_addr <= next_addr_sr[ARRAY_ADDR_W-1:0];
         end
      end else if (launch && gidx == 2'h0) begin
         mem_addr <= mem_addr + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // data launch on falling serial clock
   // ------------------------------------------------------------
   logic [7:0] byte_sr, cur_byte;
   logic four;
   assign four = (kind == KIND_FOUR_OUT);
   assign cur_byte = (gidx == 2'h0) ? mem_rdata : byte_sr;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         io_out <= 4'h0;
         io_oe <= 4'h0;
         byte_sr <= 8'h00;
         gidx <= 2'h0;
      end else if (!cs_act) begin
         io_oe <= 4'h0;
         gidx <= 2'h0;
      end else if (launch) begin
         if (four) begin
            io_out <= cur_byte[7:4];
            io_oe <= 4'hF;
            byte_sr <= {cur_byte[3:0], 4'h0};
            gidx <= (gidx == 2'h1) ? 2'h0 : 2'h1;
         end else begin
            io_out <= {2'b00, cur_byte[7:6]};
            io_oe <= 4'h3;
            byte_sr <= {cur_byte[5:0], 2'b00};
            gidx <= gidx + 2'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // mode byte and continuous read
   // ------------------------------------------------------------
   logic [7:0] mode_sr;
   logic mode_done;
   logic [3:0] frame_clks;
   logic short_exit;
   assign short_exit = cont_frame && frame_clks <= CONT_EXIT_MAX_CLOCKS;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_sr <= 8'h00;
         mode_done <= 1'b0;
         frame_clks <= 4'h0;
         cont_frame <= 1'b0;
         continuous_read <= 1'b0;
      end else if (cs_fall) begin
         mode_done <= 1'b0;
         frame_clks <= 4'h0;
         cont_frame <= continuous_read;
      end else if (cs_rise) begin
         if (short_exit) begin
            continuous_read <= 1'b0;
         end else if (mode_done) begin
            continuous_read <= (mode_sr[7:4] == MODE_KEEP_NIBBLE);
         end
      end else if (sck_rise) begin
         if (frame_clks != 4'hF) begin
            frame_clks <= frame_clks + 4'h1;
         end
         if (state == ST_MODE) begin
            mode_sr <= {mode_sr[5:0], io_s2[1:0]};
            mode_done <= (cnt == 6'h01);
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   logic [5:0] dummy_load, dummy_falls;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dummy_load <= 6'h00;
         dummy_falls <= 6'h00;
      end else begin
         if (state != ST_DUMMY) begin
            dummy_load <= dummy_len(kind, lat_code);
            dummy_falls <= 6'h00;
         end else if (sck_fall) begin
            dummy_falls <= dummy_falls + 6'h01;
         end
      end
   end

   sequence s_first_launch;
      state == ST_DUMMY && cnt == 6'h00 && sck_fall;
   endsequence

   sequence s_wide_decode;
      state == ST_CMD && sck_rise && cnt == 6'h01 &&
         (next_instr == CMD_TWO_OUT_WIDE || next_instr == CMD_TWO_IO_WIDE);
   endsequence

   deselect_idle_a: assert property (
      !cs_act |=> state == ST_IDLE ##1 io_oe == 4'h0)
      else $error("read not ended by deselect");

   quad_gate_a: assert property (
      state == ST_CMD && sck_rise && cnt == 6'h01 && !quad_en &&
      next_instr == CMD_FOUR_OUT |=> state == ST_IDLE)
      else $error("four-bit read accepted without quad enable");

   wide_addr_a: assert property (
      s_wide_decode |=> wide && cnt >= 6'h10)
      else $error("wide instruction took a narrow address");

   dummy_count_a: assert property (
      s_first_launch |-> dummy_falls == dummy_load)
      else $error("dummy cycle count wrong");

   dummy_ignore_a: assert property (
      state == ST_DUMMY |=> $stable(addr_sr) && $stable(mode_sr))
      else $error("input sampled during dummy cycles");

   launch_fall_a: assert property (
      s_first_launch |=> io_oe != 4'h0 ##0 $past(sck_s3) && !$past(sck_s2))
      else $error("data not launched on falling edge");

   lane_width_a: assert property (
      io_oe != 4'h0 |-> io_oe == (four ? 4'hF : 4'h3))
      else $error("wrong number of data lanes driven");

   addr_incr_a: assert property (
      launch && gidx == 2'h0 |=> mem_addr == $past(mem_addr) + 1'b1)
      else $error("address not incremented per byte");

   cont_keep_a: assert property (
      cs_rise && mode_done && !short_exit &&
      mode_sr[7:4] == MODE_KEEP_NIBBLE |=> continuous_read ##1
      (!cs_fall or state == ST_ADDR))
      else $error("continuous read not kept");

   cont_leave_a: assert property (
      cs_rise && mode_done && mode_sr[7:4] != MODE_KEEP_NIBBLE
      |=> !continuous_read)
      else $error("continuous read not left");

   short_exit_a: assert property (
      cs_rise && short_exit |=> !continuous_read [*2])
      else $error("short frame did not leave continuous read");

endmodule // mfr_read_front

/* File: hdl/mfr_pkg.sv */
// constants and types for the multi-bit flash read front end
package mfr_pkg;

   // ------------------------------------------------------------
   // instruction codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_TWO_OUT = 8'h3B;
   localparam logic [7:0] CMD_TWO_OUT_WIDE = 8'h3C;
   localparam logic [7:0] CMD_FOUR_OUT = 8'h6B;
   localparam logic [7:0] CMD_FOUR_OUT_WIDE = 8'h6C;
   localparam logic [7:0] CMD_TWO_IO = 8'hBB;
   localparam logic [7:0] CMD_TWO_IO_WIDE = 8'hBC;

   // ------------------------------------------------------------
   // frame layout
   // ------------------------------------------------------------
   localparam logic [5:0] INSTR_BITS = 6'h08;
   localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
   localparam logic [5:0] ADDR_BITS_WIDE = 6'h20;
   localparam logic [5:0] MODE_CYCLES = 6'h04;
   localparam logic [3:0] MODE_KEEP_NIBBLE = 4'hA;
   localparam logic [3:0] CONT_EXIT_MAX_CLOCKS = 4'h8;

   // ------------------------------------------------------------
   // configuration register one fields and latency
   // ------------------------------------------------------------
   localparam int QUAD_ENABLE_BIT = 1;
   localparam int LAT_CODE_MSB = 7;
   localparam int LAT_CODE_LSB = 6;
   localparam logic [1:0] LAT_CODE_NO_DUMMY = 2'h3;
   localparam logic [5:0] OUT_DUMMY_CYCLES = 6'h08;
   localparam logic [5:0] IO_DUMMY_CODE0 = 6'h04;
   localparam logic [5:0] IO_DUMMY_CODE1 = 6'h05;
   localparam logic [5:0] IO_DUMMY_CODE2 = 6'h06;
   localparam logic [5:0] IO_DUMMY_CODE3 = 6'h00;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      KIND_TWO_OUT = 2'h0,
      KIND_FOUR_OUT = 2'h1,
      KIND_TWO_IO = 2'h2
   } mfr_kind_e;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_CMD = 6'h02,
      ST_ADDR = 6'h04,
      ST_MODE = 6'h08,
      ST_DUMMY = 6'h10,
      ST_DATA = 6'h20
   } mfr_state_e;

endpackage

/* File: tb/mfr_host_model.sv */
// host serial controller model driving the flash read front end
`timescale 1ns/100ps

module mfr_host_model (
   output logic serial_clk, // link clock, low between frames
   output logic chip_sel_n, // chip select, low active
   output logic [3:0] io_in, // resolved io line levels
   input wire logic [3:0] io_out, // device drive values
   input wire logic [3:0] io_oe // device drive enables
);
   // ---------------------------------------------
   // wire resolution and link tasks
   // ---------------------------------------------
   logic [3:0] hv;

   // device wins where it drives, else host value or churn
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         io_in[i] = io_oe[i] ? io_out[i] : hv[i];
      end
   end

   initial begin
      serial_clk = 1'b0;
      chip_sel_n = 1'b1;
      hv = 4'h0;
   end

   task automatic sel();
      chip_sel_n = 1'b0;
      #80;
   endtask

   // drive after the fall, capture just before the next fall
   task automatic cyc(input logic [3:0] v, input logic [3:0] oe,
                      output logic [7:0] cap);
      hv = (v & oe) | (~hv & ~oe);
      #80 serial_clk = 1'b1;
      #80 cap = {io_oe, io_in};
      serial_clk = 1'b0;
   endtask

   task automatic desel();
      #80 chip_sel_n = 1'b1;
      hv = ~hv;
      #160;
   endtask
endmodule // mfr_host_model

/* File: tb/mfr_read_front_tb_top.sv */
// self-checking bench for the flash read front end
`timescale 1ns/100ps

module mfr_read_front_tb_top import mfr_pkg::*;;
   logic core_clk;
   logic rst;
   logic serial_clk;
   logic chip_sel_n;
   logic [3:0] io_in;
   logic [3:0] io_out;
   logic [3:0] io_oe;
   logic ext_flag;
   logic [7:0] cfg;
   logic enh;
   logic [23:0] mem_addr;
   logic [7:0] mem_rdata;
   logic cont;
   int failures;
   int n_checks;
   logic [7:0] c;
   logic [7:0] cmds [6];

   mfr_read_front #(.ARRAY_ADDR_W(24)) mfr_read_front_inst (
      .core_clk(core_clk), .rst(rst), .serial_clk(serial_clk),
      .chip_sel_n(chip_sel_n), .io_in(io_in), .io_out(io_out),
      .io_oe(io_oe), .extended_address_flag(ext_flag),
      .configuration_register_one(cfg), .enhanced_latency(enh),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata),
      .continuous_read(cont));

   mfr_host_model mfr_host_model_inst (
      .serial_clk(serial_clk), .chip_sel_n(chip_sel_n), .io_in(io_in),
      .io_out(io_out), .io_oe(io_oe));

   // ---------------------------------------------
   // clock, array model, checking
   // ---------------------------------------------
   initial core_clk = 1'b0;
   always #10 core_clk = ~core_clk;

   function automatic logic [7:0] mem_byte(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
   endfunction

   // synchronous array, one cycle behind the address
   always @(posedge core_clk) mem_rdata <= mem_byte(mem_addr);

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // one read frame; skip drops the instruction byte
   task automatic frame(input logic [7:0] cmd, input logic skip,
      input logic [31:0] addr, input logic [7:0] mode, input int nb,
      input logic refuse);
      logic io;
      logic [1:0] code;
      int w;
      int al;
      int aw;
      int nd;
      int nm;
      logic [7:0] got;
      logic [31:0] a;
      logic [32:0] ax;
      io = (cmd == CMD_TWO_IO) || (cmd == CMD_TWO_IO_WIDE);
      code = cfg[LAT_CODE_MSB:LAT_CODE_LSB];
      w = (cmd == CMD_FOUR_OUT || cmd == CMD_FOUR_OUT_WIDE) ? 4 : 2;
      al = io ? 2 : 1;
      aw = (ext_flag || cmd == CMD_TWO_OUT_WIDE ||
         cmd == CMD_FOUR_OUT_WIDE || cmd == CMD_TWO_IO_WIDE) ? 32 : 24;
      nd = (code == 2'h3) ? 0 : (io ? 4 + int'(code) : 8);
      nm = (io && enh) ? 4 : 0;
      a = addr;
      ax = {1'b0, addr};
      mfr_host_model_inst.sel();
      for (int i = 7; i >= 0 && !skip; i--) begin
         mfr_host_model_inst.cyc({3'h0, cmd[i]}, 4'h1, c);
      end
      for (int i = aw - al; i >= 0; i -= al) begin
         mfr_host_model_inst.cyc({2'h0, io & ax[i+1], ax[i]},
            io ? 4'h3 : 4'h1, c);
      end
      for (int k = 0; k < nm; k++) begin
         mfr_host_model_inst.cyc({2'h0, mode[7-2*k], mode[6-2*k]},
            (k < 2) ? 4'h3 : 4'h0, c);
      end
      for (int k = 0; k < nd; k++) begin
         mfr_host_model_inst.cyc(4'h0, 4'h0, c);
         chk({4'h0, c[7:4]}, 8'h00);
      end
      for (int i = 0; i < nb; i++) begin
         got = 8'h00;
         for (int k = 0; k < 8 / w; k++) begin
            mfr_host_model_inst.cyc(4'h0, 4'h0, c);
            got = (w == 4) ? {got[3:0], c[3:0]} : {got[5:0], c[1:0]};
            chk({4'h0, c[7:4]}, refuse ? 8'h00 :
               (w == 4 ? 8'h0F : 8'h03));
         end
         if (!refuse) chk(got, mem_byte(a[23:0]));
         a = a + 32'h1;
      end
      mfr_host_model_inst.desel();
      chk({4'h0, io_oe}, 8'h00);
   endtask

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      failures = 0;
      n_checks = 0;
      rst = 1'b1;
      ext_flag = 1'b0;
      cfg = 8'h02;
      enh = 1'b0;
      cmds = '{CMD_TWO_OUT, CMD_TWO_OUT_WIDE, CMD_FOUR_OUT,
         CMD_FOUR_OUT_WIDE, CMD_TWO_IO, CMD_TWO_IO_WIDE};
      repeat (5) @(posedge core_clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      foreach (cmds[j]) begin
         frame(cmds[j], 1'b0, 32'hA512_3456, 8'h00, 3, 1'b0);
      end
      ext_flag = 1'b1;
      cfg = 8'hC2;
      for (int j = 0; j < 6; j += 2) begin
         frame(cmds[j], 1'b0, 32'h00FF_FFFE, 8'h00, 4, 1'b0);
      end
      ext_flag = 1'b0;
      for (int j = 1; j < 3; j++) begin
         cfg = {j[1:0], 6'h02};
         frame(CMD_TWO_IO, 1'b0, 32'h0000_0100, 8'h00, 2, 1'b0);
      end
      cfg = 8'h00;
      frame(CMD_FOUR_OUT, 1'b0, 32'h0000_0040, 8'h00, 2, 1'b1);
      cfg = 8'h02;
      enh = 1'b1;
      frame(CMD_TWO_IO, 1'b0, 32'h0000_4000, 8'hA5, 2, 1'b0);
      chk({7'h0, cont}, 8'h01);
      frame(CMD_TWO_IO, 1'b1, 32'h0000_8001, 8'h3C, 2, 1'b0);
      chk({7'h0, cont}, 8'h00);
      frame(CMD_TWO_IO_WIDE, 1'b0, 32'h0102_0304, 8'hAF, 1, 1'b0);
      chk({7'h0, cont}, 8'h01);
      mfr_host_model_inst.sel();
      repeat (8) mfr_host_model_inst.cyc(4'h3, 4'h3, c);
      mfr_host_model_inst.desel();
      chk({7'h0, cont}, 8'h00);
      frame(CMD_TWO_OUT, 1'b0, 32'h0000_0200, 8'h00, 2, 1'b0);
      results();
   end

   // hang guard
   initial begin
      repeat (100000) @(posedge core_clk);
      failures++;
      results();
   end
endmodule // mfr_read_front_tb_top
